// *** lcdpf_cfg.svh ***
// Purpose: Constants for the LCD controller pin-function block
// Assumes: Included by bare name
// Notes:   Registers are kept by index; APB byte address is four times it
`ifndef LCDPF_CFG_SVH
`define LCDPF_CFG_SVH
`define LCDPF_HOST_RDY   3'h0
`define LCDPF_HOST_WAIT  3'h1
`define LCDPF_HOST_SACK1 3'h3
`define LCDPF_HOST_SACK2 3'h5
`define LCDPF_HOST_GEN   3'h7
`define LCDPF_IDX_PANEL  10'h002
`define LCDPF_IDX_MISC   10'h003
`define LCDPF_IDX_GPIO   10'h004
`define LCDPF_IDX_STAT   10'h005
`define LCDPF_OFF_PANEL  {`LCDPF_IDX_PANEL, 2'b00}
`define LCDPF_OFF_MISC   {`LCDPF_IDX_MISC, 2'b00}
`define LCDPF_OFF_GPIO   {`LCDPF_IDX_GPIO, 2'b00}
`define LCDPF_OFF_STAT   {`LCDPF_IDX_STAT, 2'b00}
`define LCDPF_PTYPE_LSB  4
`define LCDPF_INVV_BIT   1
`define LCDPF_PSAVE_BIT  2
`define LCDPF_PANEL_POWER_ENABLE_BIT 3
`endif

// *** lcdpf_pkg.sv ***
// Purpose: Types for the LCD controller pin-function block
// Assumes: Nothing
// Notes:   Types only; numbers live in the cfg header
package lcdpf_pkg;
  typedef enum {LCDPF_RDY, LCDPF_WAIT, LCDPF_SACK1, LCDPF_SACK2, LCDPF_GEN1, LCDPF_GEN2,
                LCDPF_RSVD} lcdpf_host_t;
  typedef enum {LCDPF_MONO, LCDPF_CSTN, LCDPF_CSTN_F1, LCDPF_TFT} lcdpf_panel_t;
  typedef struct packed {
    logic       big_endian;
    logic [2:0] host_sel;
    logic       bus_start;
  } lcdpf_strap_t;
endpackage

// *** lcdpf_sync.sv ***
// Purpose: Two-flop synchroniser
// Assumes: Input from another domain
// Notes:   First flop read only by the second
`timescale 1ns/1ps
`default_nettype none
module lcdpf_sync #(parameter int W = 1) (
  input  wire logic         clk,  // Clock
  input  wire logic         rst,  // Sync reset
  input  wire logic [W-1:0] d,    // Async in
  output logic      [W-1:0] q     // Synced
);
  logic [W-1:0] m_r;
  // Double flop
  always_ff @(posedge clk) begin
    if (rst) begin
      m_r <= '0;
      q   <= '0;
    end else begin
      m_r <= d;
      q   <= m_r;
    end
  end
endmodule // lcdpf_sync
`default_nettype wire

// *** lcdpf_hostdec.sv ***
// Purpose: Strap decode to host bus personality
// Assumes: Straps already latched
// Notes:   Pure combinational
`timescale 1ns/1ps
`default_nettype none
`include "lcdpf_cfg.svh"
module lcdpf_hostdec
  import lcdpf_pkg::*;
(
  input  wire lcdpf_strap_t strap,  // Latched straps
  output lcdpf_host_t       host    // Personality
);
  // Reserved codes map to a safe idle mode
  always_comb begin
    case (strap.host_sel)
      `LCDPF_HOST_RDY:   host = LCDPF_RDY;
      `LCDPF_HOST_WAIT:  host = LCDPF_WAIT;
      `LCDPF_HOST_SACK1: host = LCDPF_SACK1;
      `LCDPF_HOST_SACK2: host = LCDPF_SACK2;
      `LCDPF_HOST_GEN:   host = strap.bus_start ? LCDPF_GEN2 : LCDPF_GEN1;
      default:           host = LCDPF_RSVD;
    endcase
  end
endmodule // lcdpf_hostdec
`default_nettype wire

// *** lcdpf_top.sv ***
// Purpose: Host pin personality and panel pin muxing
// Assumes: SYS_CLK 20 MHz, SRST synchronous active high
// Notes:   Registers on APB; panel timing comes from core inputs
// Behaviour
// - Wait and ready variants take the read pin as active-low read.
// - Generic one: read pin is low-byte read; rd/wr pin is high-byte read.
// - Generic two: read pin is one active-low read for the access.
// - Strobe-ack two: read pin is transfer size bit 1.
// - Wait variant: wait pin low stretches the cycle.
// - Ready variant: wait pin low signals access complete.
// - Strobe-ack one: wait pin is transfer acknowledge, active low.
// - Strobe-ack two: wait pin is size ack bit 1, 16-bit port.
// - Generic modes: wait pin is active-low wait.
// - Reset returns all control registers to defaults.
// - Reset forces outputs inactive, except PREADY, PSLVERR and BIG_ENDIAN.
// - Data pins 10..8 panel data for TFT, else GPIO 3..1, inputs in reset.
// - Data pin 11 panel data for TFT, else GPIO 4 or invert input.
// - Timing output is display enable, bias toggle or second shift clock.
// - Panel power enable, active high, low in reset.
// - Straps sampled at reset: endian and host select.
// - Control bit picks general_io_zero as GPIO or power-save input.
// - Inverse video on pin 11 only when its control bit is set.
`timescale 1ns/1ps
`default_nettype none
`include "lcdpf_cfg.svh"
module lcdpf_top
  import lcdpf_pkg::*;
(
  input  wire logic        SYS_CLK,         // 20 MHz clock
  input  wire logic        SRST,            // Sync reset, high
  input  wire logic        PSEL,            // APB select
  input  wire logic        PENABLE,         // APB enable
  input  wire logic        PWRITE,          // APB direction
  input  wire logic [11:0] PADDR,           // APB address
  input  wire logic [31:0] PWDATA,          // APB write data
  output logic      [31:0] PRDATA,          // APB read data
  output logic             PREADY,          // APB ready
  output logic             PSLVERR,         // APB error
  input  wire logic [3:0]  STRAP_CONFIG_INPUTS, // Straps
  input  wire logic        BUS_START_N,     // Bus start pin
  input  wire logic        CS_N,            // Chip select
  input  wire logic        RD_N,            // Shared read pin
  input  wire logic        RD_WR_N,         // Read/write pin
  input  wire logic        CORE_INPUT_CLOCK,// Sampled link clock
  input  wire logic        CORE_BUSY,       // Core cannot finish access
  output logic             HOST_READ,       // Decoded read
  output logic             HOST_READ_LO,    // Low byte read
  output logic             HOST_READ_HI,    // High byte read
  output logic             TRANSFER_SIZE_BIT1, // Size bit 1
  output logic             BIG_ENDIAN,      // Latched endian
  output logic             WAIT_O,          // Wait/ack pin level
  output logic             WAIT_OE,         // Wait/ack pin enable
  input  wire logic [7:0]  CORE_PANEL_DATA, // Core data 7..0
  input  wire logic [3:0]  CORE_PANEL_DATA_HI, // Core data 11..8
  input  wire logic        CORE_FRAME,      // Core frame pulse
  input  wire logic        CORE_LINE,       // Core line pulse
  input  wire logic        CORE_SHIFT,      // Core shift clock
  input  wire logic        CORE_DE,         // Core display enable
  input  wire logic        CORE_BIAS,       // Core bias toggle
  input  wire logic        CORE_SHIFT2,     // Core second shift
  output logic [7:0]       PANEL_DATA,      // Panel data 7..0
  input  wire logic [3:0]  PANEL_DATA_HI_I, // Pins 11..8 in
  output logic [3:0]       PANEL_DATA_HI_O, // Pins 11..8 out
  output logic [3:0]       PANEL_DATA_HI_OE,// Pins 11..8 enable
  output logic             PANEL_FRAME_PULSE, // Frame
  output logic             PANEL_LINE_PULSE,  // Line
  output logic             PANEL_SHIFT_CLOCK, // Shift
  output logic             PANEL_DISPLAY_ENABLE, // Multi-function timing
  output logic             PANEL_POWER_ENABLE,   // Panel power
  input  wire logic        GENERAL_IO_ZERO_I,  // Pin in
  output logic             GENERAL_IO_ZERO_O,  // Pin out
  output logic             GENERAL_IO_ZERO_OE, // Pin enable
  output logic             POWER_SAVE_REQ,     // Hardware power save
  output logic             INVERSE_VIDEO       // Hardware invert
);
  ////////////////////////////////////////////////////////////////////////
  // Synchronisers for pin inputs
  logic [3:0] strap_s;
  logic [8:0] pins_s;
  lcdpf_sync #(.W(4)) u_sync_strap (.clk(SYS_CLK), .rst(1'b0), .d(STRAP_CONFIG_INPUTS),
                                    .q(strap_s));
  // No reset here: a reset value would fake chip select and bus start low
  lcdpf_sync #(.W(9)) u_sync_pins (.clk(SYS_CLK), .rst(1'b0),
    .d({BUS_START_N, CS_N, RD_N, RD_WR_N, CORE_INPUT_CLOCK, PANEL_DATA_HI_I}),
    .q(pins_s));
  logic bs_s, cs_n_s, rd_n_s, rdwr_n_s, cki_s;
  logic [3:0] hi_in_s;
  assign {bs_s, cs_n_s, rd_n_s, rdwr_n_s, cki_s, hi_in_s} = pins_s;
  logic gp0_s;
  lcdpf_sync #(.W(1)) u_sync_gp0 (.clk(SYS_CLK), .rst(SRST), .d(GENERAL_IO_ZERO_I),
                                  .q(gp0_s));

  ////////////////////////////////////////////////////////////////////////
  // Strap capture while reset is held; straps need three cycles of reset
  lcdpf_strap_t strap_r;
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      strap_r <= '{big_endian: strap_s[3], host_sel: strap_s[2:0], bus_start: bs_s};
    end
  end
  lcdpf_host_t host;
  lcdpf_hostdec u_dec (.strap(strap_r), .host(host));
  assign BIG_ENDIAN = strap_r.big_endian;

  ////////////////////////////////////////////////////////////////////////
  // Control registers
  logic [1:0]  panel_r;        // Panel type
  logic        invv_r;         // Inverse video enable
  logic [7:0]  misc_r;         // Mode bits
  logic [4:0]  gpio_out_r;     // GPIO 4..0 out
  logic [4:0]  gpio_dir_r;     // GPIO 4..0 direction
  logic        apb_wr, apb_rd;
  assign apb_wr = PSEL && PENABLE && PWRITE;
  assign apb_rd = PSEL && PENABLE && !PWRITE;
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `LCDPF_OFF_PANEL) || (a == `LCDPF_OFF_MISC) ||
             (a == `LCDPF_OFF_GPIO) || (a == `LCDPF_OFF_STAT);
  endfunction
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped(PADDR);
  // Register writes
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      panel_r    <= 2'h0;
      invv_r     <= 1'b0;
      misc_r     <= 8'h00;
      gpio_out_r <= 5'h00;
      gpio_dir_r <= 5'h00;
    end else if (apb_wr) begin
      case (PADDR)
        `LCDPF_OFF_PANEL: begin
          panel_r <= PWDATA[`LCDPF_PTYPE_LSB+1:`LCDPF_PTYPE_LSB];
          invv_r  <= PWDATA[`LCDPF_INVV_BIT];
        end
        `LCDPF_OFF_MISC:  misc_r  <= PWDATA[7:0];
        `LCDPF_OFF_GPIO: begin
          gpio_out_r <= PWDATA[4:0];
          gpio_dir_r <= PWDATA[12:8];
        end
        default: ;
      endcase
    end
  end
  logic [4:0] gpio_in;
  assign gpio_in = {hi_in_s, gp0_s};
  // Read data from flops
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      case (PADDR)
        `LCDPF_OFF_PANEL: PRDATA <= {26'h0, panel_r, 2'h0, invv_r, 1'b0};
        `LCDPF_OFF_MISC:  PRDATA <= {24'h0, misc_r};
        `LCDPF_OFF_GPIO:  PRDATA <= {11'h0, gpio_in, 3'h0, gpio_dir_r, 3'h0, gpio_out_r};
        `LCDPF_OFF_STAT:  PRDATA <= {27'h0, strap_r};
        default:          PRDATA <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Host read pin decode per personality
  always_comb begin
    HOST_READ          = 1'b0;
    HOST_READ_LO       = 1'b0;
    HOST_READ_HI       = 1'b0;
    TRANSFER_SIZE_BIT1 = 1'b0;
    if (!SRST && !cs_n_s) begin
      case (host)
        LCDPF_RDY, LCDPF_WAIT: HOST_READ = !rd_n_s;
        LCDPF_GEN1: begin
          HOST_READ_LO = !rd_n_s;
          HOST_READ_HI = !rdwr_n_s;
          HOST_READ    = !rd_n_s || !rdwr_n_s;
        end
        LCDPF_GEN2:  HOST_READ = !rd_n_s;
        LCDPF_SACK2: TRANSFER_SIZE_BIT1 = rd_n_s;
        LCDPF_SACK1: HOST_READ = 1'b0;
        default:     HOST_READ = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wait/ack pin: core busy means not yet complete
  logic done;
  assign done = !CORE_BUSY;
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      WAIT_O  <= 1'b1;
      WAIT_OE <= 1'b0;
    end else begin
      WAIT_OE <= !cs_n_s && (host != LCDPF_RSVD);
      case (host)
        LCDPF_WAIT:  WAIT_O <= !CORE_BUSY;
        LCDPF_RDY:   WAIT_O <= !done;
        LCDPF_SACK1: WAIT_O <= !done;
        LCDPF_SACK2: WAIT_O <= !done;
        LCDPF_GEN1, LCDPF_GEN2: WAIT_O <= !CORE_BUSY;
        default:     WAIT_O <= 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Link clock level registered once more to gate the shift clock
  logic cki_d_r;
  always_ff @(posedge SYS_CLK) begin
    if (SRST) cki_d_r <= 1'b0;
    else      cki_d_r <= cki_s;
  end

  ////////////////////////////////////////////////////////////////////////
  // Panel outputs, all registered; low throughout reset
  lcdpf_panel_t ptype;
  always_comb begin
    case (panel_r)
      2'h0:    ptype = LCDPF_MONO;
      2'h1:    ptype = LCDPF_CSTN;
      2'h2:    ptype = LCDPF_CSTN_F1;
      default: ptype = LCDPF_TFT;
    endcase
  end
  logic tft;
  assign tft = (ptype == LCDPF_TFT);
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      PANEL_DATA           <= 8'h00;
      PANEL_FRAME_PULSE    <= 1'b0;
      PANEL_LINE_PULSE     <= 1'b0;
      PANEL_SHIFT_CLOCK    <= 1'b0;
      PANEL_DISPLAY_ENABLE <= 1'b0;
      PANEL_POWER_ENABLE   <= 1'b0;
    end else begin
      PANEL_DATA        <= CORE_PANEL_DATA;
      PANEL_FRAME_PULSE <= CORE_FRAME;
      PANEL_LINE_PULSE  <= CORE_LINE;
      PANEL_SHIFT_CLOCK <= CORE_SHIFT && cki_d_r;
      PANEL_POWER_ENABLE <= misc_r[`LCDPF_PANEL_POWER_ENABLE_BIT];
      case (ptype)
        LCDPF_TFT:     PANEL_DISPLAY_ENABLE <= CORE_DE;
        LCDPF_CSTN_F1: PANEL_DISPLAY_ENABLE <= CORE_SHIFT2;
        default:       PANEL_DISPLAY_ENABLE <= CORE_BIAS;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Multi-function pins 11..8 and general_io_zero
  logic inv_en, psave_en;
  assign inv_en   = invv_r && !tft;
  assign psave_en = misc_r[`LCDPF_PSAVE_BIT];
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_hi
      always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
          PANEL_DATA_HI_O[gi]  <= 1'b0;
          PANEL_DATA_HI_OE[gi] <= 1'b0;
        end else if (tft) begin
          PANEL_DATA_HI_O[gi]  <= CORE_PANEL_DATA_HI[gi];
          PANEL_DATA_HI_OE[gi] <= 1'b1;
        end else begin
          PANEL_DATA_HI_O[gi]  <= gpio_out_r[gi+1];
          PANEL_DATA_HI_OE[gi] <= gpio_dir_r[gi+1] && !(gi == 3 && inv_en);
        end
      end
    end
  endgenerate
  // Invert input from pin 11 only when enabled
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      INVERSE_VIDEO      <= 1'b0;
      POWER_SAVE_REQ     <= 1'b0;
      GENERAL_IO_ZERO_O  <= 1'b0;
      GENERAL_IO_ZERO_OE <= 1'b0;
    end else begin
      INVERSE_VIDEO      <= inv_en && hi_in_s[3];
      POWER_SAVE_REQ     <= psave_en && gp0_s;
      GENERAL_IO_ZERO_O  <= gpio_out_r[0];
      GENERAL_IO_ZERO_OE <= gpio_dir_r[0] && !psave_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  a_reset_panel_low: assert property (@(posedge SYS_CLK)
    $past(SRST) |-> (PANEL_DATA == 8'h00) && !PANEL_FRAME_PULSE && !PANEL_SHIFT_CLOCK)
    else $error("panel outputs not low after reset");
  a_reset_power_low: assert property (@(posedge SYS_CLK)
    $past(SRST) |-> !PANEL_POWER_ENABLE)
    else $error("panel power high in reset");
  a_wait_release_cs: assert property (@(posedge SYS_CLK) disable iff (SRST)
    $past(cs_n_s) && !$past(SRST) |-> !WAIT_OE)
    else $error("wait driven without chip select");
  a_wait_busy_hold: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (host == LCDPF_WAIT) && CORE_BUSY && !$past(SRST) |=> !WAIT_O)
    else $error("wait not asserted while busy");
  a_ack_done: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (host == LCDPF_SACK1) && !CORE_BUSY |=> !WAIT_O)
    else $error("acknowledge missing");
  a_gen_read_lo: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (host == LCDPF_GEN1) && !cs_n_s && !rd_n_s |-> HOST_READ_LO && !TRANSFER_SIZE_BIT1)
    else $error("low byte read missed");
  a_size_bit_one: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (host == LCDPF_SACK2) && !cs_n_s |-> (TRANSFER_SIZE_BIT1 == rd_n_s) && !HOST_READ)
    else $error("size bit decode wrong");
  a_invert_gate: assert property (@(posedge SYS_CLK) disable iff (SRST)
    INVERSE_VIDEO |-> $past(invv_r))
    else $error("invert without enable");
  a_tft_hi_drive: assert property (@(posedge SYS_CLK) disable iff (SRST)
    tft ##1 !$past(SRST) |-> PANEL_DATA_HI_OE == 4'hf)
    else $error("tft high data not driven");
endmodule // lcdpf_top
`default_nettype wire

// *** lcdpf_far_model.sv ***
// Purpose: Host bus controller and panel-side pin model
// Assumes: Bench changes kind right after a SYS_CLK rise
// Notes:   Released lines settle at their pull-up level
`timescale 1ns/1ps
`default_nettype none
module lcdpf_far_model (
  input  wire logic [2:0] kind,      // 0 idle, 1 read, 2 low, 3 high, 4 size
  input  wire logic       ack_one,   // Strobe-ack one personality
  output logic            cs_n,      // Chip select
  output logic            rd_n,      // Shared read pin
  output logic            rd_wr_n,   // Read/write pin
  input  wire logic       wait_o,    // Device wait level
  input  wire logic       wait_oe,   // Device wait enable
  output logic            wait_line, // Wire level seen by host
  input  wire logic [4:0] io_o,      // Device pin levels
  input  wire logic [4:0] io_oe,     // Device pin enables
  input  wire logic [4:0] io_ext,    // Far-side levels, pulled up when idle
  output logic [4:0]      io_line    // Resolved pin levels
);
  ////////////////////////////////////////////////////////////////////////////
  // Host puts its cycle on the shared pins; size bit 1 rides the read pin
  assign cs_n    = (kind == 3'h0);
  assign rd_n    = ack_one | !(kind == 3'h1 || kind == 3'h2);
  assign rd_wr_n = !(kind == 3'h3);
  ////////////////////////////////////////////////////////////////////////////
  // Wired acknowledge line needs a pull-up, else a released pin reads unknown
  assign wait_line = wait_oe ? wait_o : 1'b1;
  assign io_line   = (io_oe & io_o) | (~io_oe & io_ext);
endmodule // lcdpf_far_model
`default_nettype wire

// *** tb_top.sv ***
// Purpose: Self-checking bench for the pin-function block
// Assumes: Zero-wait APB slave, two-flop pin synchronisers
// Notes:   Each host personality needs its own reset
`timescale 1ns/1ps
`default_nettype none
`include "lcdpf_cfg.svh"
module tb_top;
  logic        SYS_CLK = 1'b0, SRST = 1'b1, CORE_INPUT_CLOCK = 1'b0, CORE_BUSY = 1'b0;
  logic        PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, BUS_START_N = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA, q;
  logic        PREADY, PSLVERR, HOST_READ, HOST_READ_LO, HOST_READ_HI, TRANSFER_SIZE_BIT1;
  logic        BIG_ENDIAN, WAIT_O, WAIT_OE, CS_N, RD_N, RD_WR_N, wait_line, e, v0, p0;
  logic [3:0]  STRAP_CONFIG_INPUTS = 4'h0, CORE_PANEL_DATA_HI = 4'ha;
  logic [7:0]  CORE_PANEL_DATA = 8'h5a, PANEL_DATA;
  logic        CORE_FRAME = 1'b1, CORE_LINE = 1'b1, CORE_SHIFT = 1'b1;
  logic        CORE_DE = 1'b1, CORE_BIAS = 1'b1, CORE_SHIFT2 = 1'b1;
  logic [3:0]  PANEL_DATA_HI_O, PANEL_DATA_HI_OE;
  logic        PANEL_FRAME_PULSE, PANEL_LINE_PULSE, PANEL_SHIFT_CLOCK, PANEL_DISPLAY_ENABLE;
  logic        PANEL_POWER_ENABLE, GENERAL_IO_ZERO_O, GENERAL_IO_ZERO_OE;
  logic        POWER_SAVE_REQ, INVERSE_VIDEO;
  logic [2:0]  kind = 3'h0;
  logic [4:0]  io_ext = 5'h1f, io_line;
  logic [7:0]  wt = 8'h72;
  int          mismatches = 0, check_count = 0;
  // Per case: strap code, host cycle, expected decode and its mask
  int          code [8] = '{0, 1, 3, 5, 7, 7, 7, 2};
  int          knd  [8] = '{1, 1, 1, 4, 2, 3, 1, 1};
  int          xp   [8] = '{8, 8, 0, 1, 4, 2, 8, 0};
  int          msk  [8] = '{8, 8, 9, 9, 6, 6, 8, 15};

  ////////////////////////////////////////////////////////////////////////////
  // Clocks; link clock offset so its edges never line up with SYS_CLK
  always #25 SYS_CLK = ~SYS_CLK;
  initial begin
    #13;
    forever #200 CORE_INPUT_CLOCK = ~CORE_INPUT_CLOCK;
  end

  lcdpf_top u_dut (
    .SYS_CLK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
    .STRAP_CONFIG_INPUTS, .BUS_START_N, .CS_N, .RD_N, .RD_WR_N, .CORE_INPUT_CLOCK,
    .CORE_BUSY, .HOST_READ, .HOST_READ_LO, .HOST_READ_HI, .TRANSFER_SIZE_BIT1, .BIG_ENDIAN,
    .WAIT_O, .WAIT_OE, .CORE_PANEL_DATA, .CORE_PANEL_DATA_HI, .CORE_FRAME, .CORE_LINE,
    .CORE_SHIFT, .CORE_DE, .CORE_BIAS, .CORE_SHIFT2, .PANEL_DATA,
    .PANEL_DATA_HI_I(io_line[4:1]), .PANEL_DATA_HI_O, .PANEL_DATA_HI_OE, .PANEL_FRAME_PULSE,
    .PANEL_LINE_PULSE, .PANEL_SHIFT_CLOCK, .PANEL_DISPLAY_ENABLE, .PANEL_POWER_ENABLE,
    .GENERAL_IO_ZERO_I(io_line[0]), .GENERAL_IO_ZERO_O, .GENERAL_IO_ZERO_OE,
    .POWER_SAVE_REQ, .INVERSE_VIDEO);

  lcdpf_far_model u_far (
    .kind, .ack_one(STRAP_CONFIG_INPUTS[2:0] == 3'h3), .cs_n(CS_N), .rd_n(RD_N),
    .rd_wr_n(RD_WR_N), .wait_o(WAIT_O), .wait_oe(WAIT_OE), .wait_line,
    .io_o({PANEL_DATA_HI_O, GENERAL_IO_ZERO_O}), .io_oe({PANEL_DATA_HI_OE, GENERAL_IO_ZERO_OE}),
    .io_ext, .io_line);

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic tick(input int n);
    repeat (n) @(posedge SYS_CLK);
  endtask
  task automatic look();
    @(negedge SYS_CLK);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Entered just after a rising edge; request held until PREADY seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    PSEL   <= 1'b1;
    PWRITE <= w;
    PADDR  <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge SYS_CLK);
    end while (PREADY !== 1'b1);
    q = PRDATA;
    e = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge SYS_CLK);
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog, far beyond the expected run
  initial begin
    #2_000_000;
    mismatches++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host personalities: one reset each, then read decode and wait pin
  initial begin
    for (int i = 0; i < 8; i++) begin
      tick(1);
      STRAP_CONFIG_INPUTS <= {i[0], code[i][2:0]};
      BUS_START_N <= (i == 6);
      SRST <= 1'b1;
      tick(15);
      look();
      chk({PANEL_DATA, PANEL_FRAME_PULSE, PANEL_LINE_PULSE, PANEL_SHIFT_CLOCK}, 0);
      chk({PANEL_POWER_ENABLE, PANEL_DISPLAY_ENABLE, INVERSE_VIDEO, POWER_SAVE_REQ}, 0);
      chk({WAIT_OE, PANEL_DATA_HI_OE, GENERAL_IO_ZERO_OE}, 0);
      tick(1);
      SRST <= 1'b0;
      tick(1);
      apb(1'b0, `LCDPF_OFF_STAT, 32'h0);
      chk(q[4:0], {i[0], code[i][2:0], i == 6});
      chk(BIG_ENDIAN, i[0]);
      kind <= knd[i][2:0];
      tick(6);
      look();
      chk({HOST_READ, HOST_READ_LO, HOST_READ_HI, TRANSFER_SIZE_BIT1} & msk[i], xp[i]);
      for (int b = 1; b >= 0; b--) begin
        tick(1);
        CORE_BUSY <= b[0];
        tick(4);
        look();
        chk({WAIT_OE, wait_line}, (i == 7) ? 2'b01 : {1'b1, b[0] ^ wt[i]});
      end
      tick(1);
      kind <= 3'h0;
      tick(5);
      look();
      chk({WAIT_OE, wait_line, HOST_READ}, 3'b010);
    end
    // Register defaults and an unmapped place
    tick(1);
    apb(1'b0, `LCDPF_OFF_PANEL, 32'h0);
    chk(q, 0);
    apb(1'b0, `LCDPF_OFF_MISC, 32'h0);
    chk(q, 0);
    apb(1'b0, `LCDPF_OFF_GPIO, 32'h0);
    chk(q, 32'h001f0000);
    apb(1'b1, 12'h020, 32'hffffffff);
    chk(e, 1);
    apb(1'b0, 12'h020, 32'h0);
    chk({e, q[30:0]}, 32'h80000000);
    // Timing output source and upper data pins per panel type
    for (int t = 0; t < 4; t++) begin
      apb(1'b1, `LCDPF_OFF_PANEL, t << `LCDPF_PTYPE_LSB);
      {CORE_DE, CORE_BIAS, CORE_SHIFT2} <= (t == 3) ? 3'b100 : (t == 2) ? 3'b001 : 3'b010;
      tick(3);
      look();
      chk(PANEL_DISPLAY_ENABLE, 1);
      chk({PANEL_DATA_HI_OE, PANEL_DATA_HI_O & {4{t == 3}}}, (t == 3) ? 8'hfa : 8'h00);
      chk({PANEL_DATA, PANEL_FRAME_PULSE, PANEL_LINE_PULSE, PREADY}, 11'h2d7);
      tick(1);
    end
    // General-purpose pins driven out, then read back through the pins
    apb(1'b1, `LCDPF_OFF_PANEL, 32'h0);
    apb(1'b1, `LCDPF_OFF_GPIO, 32'h00001f15);
    tick(5);
    look();
    chk({PANEL_DATA_HI_OE, PANEL_DATA_HI_O, GENERAL_IO_ZERO_OE, GENERAL_IO_ZERO_O}, 10'h3eb);
    tick(1);
    apb(1'b0, `LCDPF_OFF_GPIO, 32'h0);
    chk(q, 32'h00151f15);
    apb(1'b1, `LCDPF_OFF_GPIO, 32'h0);
    // Inverse video and power save follow their pins only when enabled
    for (int m = 0; m < 2; m++) begin
      // Enable sits in the panel register; the same bit in misc must not count
      apb(1'b1, `LCDPF_OFF_PANEL, m ? 32'h02 : 32'h00);
      apb(1'b1, `LCDPF_OFF_MISC, m ? 32'h0c : 32'h0a);
      io_ext <= 5'h00;
      tick(5);
      look();
      v0 = INVERSE_VIDEO;
      p0 = POWER_SAVE_REQ;
      tick(1);
      io_ext <= 5'h1f;
      tick(5);
      look();
      chk({PANEL_POWER_ENABLE, GENERAL_IO_ZERO_OE}, 2'b10);
      if (m == 1)
        chk({v0 ^ INVERSE_VIDEO, p0 ^ POWER_SAVE_REQ}, 2'b11);
      else
        chk({v0, p0, INVERSE_VIDEO, POWER_SAVE_REQ}, 0);
      tick(1);
    end
    conclude();
  end
endmodule // tb_top
`default_nettype wire
